// file: rsbs_params.svh
// constants for the receive signaling buffer and change stack
`ifndef RSBS_PARAMS_SVH
`define RSBS_PARAMS_SVH

`define RSBS_ADDR_W           9
`define RSBS_SLOTS            32
`define RSBS_OFF_TIMER_STATUS 9'h008
`define RSBS_OFF_SBI_CFG      9'h0d0
`define RSBS_OFF_SIG_CFG      9'h0d7
`define RSBS_OFF_STACK        9'h0da
`define RSBS_OFF_PCC_BASE     9'h180
`define RSBS_OFF_SIGBUF_BASE  9'h1a0

// rx_signaling_config fields
`define RSBS_CFG_ROBBED       0
`define RSBS_CFG_FREEZE       1
`define RSBS_CFG_DEBOUNCE     2
`define RSBS_CFG_UNICODE      3
`define RSBS_CFG_EVERY_MF     4
// system_bus_interface_config field
`define RSBS_SBI_EMBED        0
// rx_per_channel_control field
`define RSBS_PCC_STACK_EN     0
// timer_interrupt_status fields
`define RSBS_ISR_SIG          0
`define RSBS_ISR_UNICODE      1
// rx_signaling_change_stack fields
`define RSBS_STK_MORE         7
`define RSBS_STK_WORD         6

// reset values
`define RSBS_RST_SIG_CFG      8'h01
`define RSBS_RST_SBI_CFG      8'h00
`define RSBS_RST_PCC          8'h00
`define RSBS_RST_SIGBUF       8'h00

// framing and slot figures
`define RSBS_FRAMES_PER_SIG   5'h06
`define RSBS_FRAMES_PER_MF    5'h18
`define RSBS_FBIT_TS          5'h1a
`define RSBS_FBIT_POS         7
`define RSBS_UNASSIGNED_TS_A  5'h00
`define RSBS_UNASSIGNED_TS_B  5'h10
`define RSBS_IDLE_BYTE        8'hff
`define RSBS_FIFO_DEPTH       8

`endif

// file: rsbs_pkg.sv
// types shared by the signaling buffer block
package rsbs_pkg;
    typedef struct packed {
        logic [4:0] ts;
        logic [7:0] data;
        logic       fbit;
    } rsbs_pcm_t;

    typedef struct packed {
        logic [4:0] chan;
        logic [3:0] abcd;
    } rsbs_stack_entry_t;

    typedef enum logic {RSBS_WORD_CHAN, RSBS_WORD_ABCD} rsbs_word_t;
endpackage : rsbs_pkg

// file: rsbs_fifo_if.sv
// valid/ready carrier between the block and its pcm fifo
`timescale 1ns/100ps
interface rsbs_fifo_if #(parameter int WIDTH = 14);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;
    modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : rsbs_fifo_if

// file: rsbs_fifo.sv
// synchronous fifo with registered ready and valid
`timescale 1ns/100ps
module rsbs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    rsbs_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             push;
    logic             pop;

    assign push      = f.wr_valid && f.wr_ready;
    assign pop       = f.rd_valid && f.rd_ready;
    assign f.rd_data = mem_q[rptr_q];

    // occupancy after this cycle's push and pop
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    // storage and pointers
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wptr_q] <= f.wr_data;
        end
        if (!rst_b) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (push) wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
            if (pop)  rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + AW'(1);
        end
    end

    // flags come straight from flops so back-pressure is clean
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            count_q    <= '0;
            f.wr_ready <= 1'b0;
            f.rd_valid <= 1'b0;
        end else begin
            count_q    <= count_d;
            f.wr_ready <= (count_d != CW'(DEPTH));
            f.rd_valid <= (count_d != '0);
        end
    end
endmodule : rsbs_fifo

// file: rsbs_top.sv
// receive signaling buffer, change stack and pcm output stage
// Notes on behaviour
// - a 32-byte buffer keeps one multiframe of signaling, byte n for time slot n.
// - each byte holds received signaling in its low nibble and outgoing signaling in its high nibble.
// - the processor reads and overwrites any buffer byte and overwritten values are then used.
// - robbed-bit signaling goes into the pcm output by multiframe timing, abcd goes out by frame timing.
// - a config register picks transparent or robbed-bit, freeze, debounce and unicode detection.
// - changes are stacked only for channels whose stack enable bit is set.
// - the stack keeps channel and new abcd for each change, with room for every channel at once.
// - at the end of a multiframe with any stacked change the signaling status bit is set and an interrupt raised.
// - the more bit is cleared once the stack is empty and the processor reads until it sees that.
// - with the every-multiframe option in t1 the interrupt comes at each multiframe boundary.
// - with embedded framing in t1 the framing bit is placed on the pcm output.
// - embedded mapping idles ts0, ts16 and ts27-31 and puts the framing bit in bit 7 of ts26.
`timescale 1ns/100ps
`include "rsbs_params.svh"
module rsbs_top #(
    parameter int SLOTS      = `RSBS_SLOTS,
    parameter int FIFO_DEPTH = `RSBS_FIFO_DEPTH
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire logic                    t1_mode,
    input  wire logic                    rx_sig_valid,
    input  wire logic [4:0]              rx_sig_ts,
    input  wire logic [3:0]              rx_sig_abcd,
    input  wire logic                    pcm_in_valid,
    input  wire logic [4:0]              pcm_in_ts,
    input  wire logic [7:0]              pcm_in_byte,
    input  wire logic                    pcm_in_fbit,
    output wire logic                    pcm_in_ready,
    input  wire logic                    rx_frame_sync,
    input  wire logic                    rx_multiframe_sync,
    input  wire logic [`RSBS_ADDR_W-1:0] proc_addr,
    input  wire logic                    proc_rd,
    input  wire logic                    proc_wr,
    input  wire logic [7:0]              proc_wdata,
    output logic      [7:0]              proc_rdata_q,
    input  wire logic                    pcm_out_ready,
    output logic                         pcm_out_valid_q,
    output logic      [4:0]              pcm_out_ts_q,
    output logic      [7:0]              rx_pcm_output_q,
    output logic      [3:0]              rx_signaling_output_q,
    output wire logic                    sig_irq
);
    localparam int FW = $bits(rsbs_pkg::rsbs_pcm_t);

    logic [7:0]                     sigbuf_q [SLOTS];
    logic [7:0]                     pcc_q    [SLOTS];
    logic [3:0]                     cand_q   [SLOTS];
    logic [7:0]                     sig_cfg_q;
    logic [7:0]                     sbi_cfg_q;
    logic [7:0]                     isr_q;
    rsbs_pkg::rsbs_stack_entry_t    stk_q    [SLOTS];
    logic [4:0]                     stk_wptr_q;
    logic [4:0]                     stk_rptr_q;
    logic [5:0]                     stk_cnt_q;
    rsbs_pkg::rsbs_word_t           word_q;
    logic                           mf_changed_q;
    logic [3:0]                     uni_val_q;
    logic                           uni_seen_q;
    logic                           uni_same_q;
    logic [2:0]                     fsync_q;
    logic [2:0]                     msync_q;
    logic [4:0]                     fcnt_q;
    logic                           frame_edge;
    logic                           mf_edge;
    logic                           accept;
    logic                           changed;
    logic                           stk_push;
    logic                           stk_pop;
    logic                           stk_rd;
    logic                           sigbuf_hit;
    logic                           pcc_hit;
    logic                           isr_rd;
    logic                           out_load;
    logic [7:0]                     rdata_d;
    logic [7:0]                     pcm_d;
    logic [1:0]                     sig_idx;
    rsbs_pkg::rsbs_pcm_t            fifo_out;

    rsbs_fifo_if #(.WIDTH(FW)) pcm_if ();

    // pcm bytes pass through the fifo so the highway can stall the source
    rsbs_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .f       (pcm_if.fifo)
    );
    assign pcm_if.wr_valid = pcm_in_valid;
    assign pcm_if.wr_data  = {pcm_in_ts, pcm_in_byte, pcm_in_fbit};
    assign pcm_in_ready    = pcm_if.wr_ready;
    assign fifo_out        = pcm_if.rd_data;
    assign out_load        = pcm_if.rd_valid && (!pcm_out_valid_q || pcm_out_ready);
    assign pcm_if.rd_ready = out_load;

    // sync pins are taken as inputs and pass two flops first; the third flop feeds edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fsync_q <= '0;
            msync_q <= '0;
        end else begin
            fsync_q <= {fsync_q[1:0], rx_frame_sync};
            msync_q <= {msync_q[1:0], rx_multiframe_sync};
        end
    end
    assign frame_edge = fsync_q[1] && !fsync_q[2];
    assign mf_edge    = msync_q[1] && !msync_q[2];

    // address decode of the processor port
    assign sigbuf_hit = (proc_addr[`RSBS_ADDR_W-1:5] == 4'(`RSBS_OFF_SIGBUF_BASE >> 5));
    assign pcc_hit    = (proc_addr[`RSBS_ADDR_W-1:5] == 4'(`RSBS_OFF_PCC_BASE >> 5));
    assign stk_rd     = proc_rd && (proc_addr == `RSBS_OFF_STACK);
    assign isr_rd     = proc_rd && (proc_addr == `RSBS_OFF_TIMER_STATUS);

    // receiver update qualified by freeze and debounce
    assign accept  = rx_sig_valid && !sig_cfg_q[`RSBS_CFG_FREEZE]
                     && (!sig_cfg_q[`RSBS_CFG_DEBOUNCE] || cand_q[rx_sig_ts] == rx_sig_abcd);
    assign changed = accept && (sigbuf_q[rx_sig_ts][3:0] != rx_sig_abcd);
    assign stk_push = changed && pcc_q[rx_sig_ts][`RSBS_PCC_STACK_EN]
                      && (stk_cnt_q != 6'(SLOTS));
    assign stk_pop  = stk_rd && (word_q == rsbs_pkg::RSBS_WORD_ABCD) && (stk_cnt_q != '0);

    // signaling buffer: processor write wins over a receiver update to the same byte
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < SLOTS; i++) begin
                sigbuf_q[i] <= `RSBS_RST_SIGBUF;
            end
        end else if (proc_wr && sigbuf_hit) begin
            sigbuf_q[proc_addr[4:0]] <= proc_wdata;
            if (accept && rx_sig_ts != proc_addr[4:0]) begin
                sigbuf_q[rx_sig_ts][3:0] <= rx_sig_abcd;
            end
        end else if (accept) begin
            sigbuf_q[rx_sig_ts][3:0] <= rx_sig_abcd;
        end
    end

    // debounce candidates: a value must arrive twice in a row for its slot to be accepted
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < SLOTS; i++) begin
                cand_q[i] <= '0;
            end
        end else if (rx_sig_valid) begin
            cand_q[rx_sig_ts] <= rx_sig_abcd;
        end
    end

    // per-channel control and configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < SLOTS; i++) begin
                pcc_q[i] <= `RSBS_RST_PCC;
            end
            sig_cfg_q <= `RSBS_RST_SIG_CFG;
            sbi_cfg_q <= `RSBS_RST_SBI_CFG;
        end else if (proc_wr) begin
            if (pcc_hit) pcc_q[proc_addr[4:0]] <= proc_wdata;
            if (proc_addr == `RSBS_OFF_SIG_CFG) sig_cfg_q <= proc_wdata;
            if (proc_addr == `RSBS_OFF_SBI_CFG) sbi_cfg_q <= proc_wdata;
        end
    end

    // change stack storage, oldest entry first
    always_ff @(posedge sys_clk) begin
        if (stk_push) begin
            stk_q[stk_wptr_q] <= '{chan: rx_sig_ts, abcd: rx_sig_abcd};
        end
        if (!rst_b) begin
            stk_wptr_q <= '0;
            stk_rptr_q <= '0;
            stk_cnt_q  <= '0;
        end else begin
            if (stk_push) stk_wptr_q <= 5'(stk_wptr_q + 5'h01);
            if (stk_pop)  stk_rptr_q <= 5'(stk_rptr_q + 5'h01);
            stk_cnt_q <= 6'(stk_cnt_q + {5'h00, stk_push} - {5'h00, stk_pop});
        end
    end

    // word select of the two-read protocol
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            word_q <= rsbs_pkg::RSBS_WORD_CHAN;
        end else if (stk_rd && stk_cnt_q != '0) begin
            unique case (word_q)
                rsbs_pkg::RSBS_WORD_CHAN: word_q <= rsbs_pkg::RSBS_WORD_ABCD;
                rsbs_pkg::RSBS_WORD_ABCD: word_q <= rsbs_pkg::RSBS_WORD_CHAN;
            endcase
        end
    end

    // change tracking and unicode detection within one multiframe
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mf_changed_q <= 1'b0;
            uni_val_q    <= '0;
            uni_seen_q   <= 1'b0;
            uni_same_q   <= 1'b1;
        end else if (mf_edge) begin
            mf_changed_q <= 1'b0;
            uni_seen_q   <= 1'b0;
            uni_same_q   <= 1'b1;
        end else begin
            if (stk_push) mf_changed_q <= 1'b1;
            if (rx_sig_valid) begin
                uni_seen_q <= 1'b1;
                uni_val_q  <= rx_sig_abcd;
                if (uni_seen_q && rx_sig_abcd != uni_val_q) uni_same_q <= 1'b0;
            end
        end
    end

    // status bits set at the multiframe end, cleared by reading, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            isr_q <= '0;
        end else begin
            if (isr_rd) isr_q <= '0;
            if (mf_edge && (mf_changed_q || (sig_cfg_q[`RSBS_CFG_EVERY_MF] && t1_mode))) begin
                isr_q[`RSBS_ISR_SIG] <= 1'b1;
            end
            if (mf_edge && sig_cfg_q[`RSBS_CFG_UNICODE] && uni_seen_q && uni_same_q) begin
                isr_q[`RSBS_ISR_UNICODE] <= 1'b1;
            end
        end
    end
    assign sig_irq = isr_q[`RSBS_ISR_SIG];

    // read data mux; stack word carries more, word select and the field
    always_comb begin
        rdata_d = 8'h00;
        if (sigbuf_hit) begin
            rdata_d = sigbuf_q[proc_addr[4:0]];
        end else if (pcc_hit) begin
            rdata_d = pcc_q[proc_addr[4:0]];
        end else begin
            unique case (proc_addr)
                `RSBS_OFF_TIMER_STATUS: rdata_d = isr_q;
                `RSBS_OFF_SIG_CFG:      rdata_d = sig_cfg_q;
                `RSBS_OFF_SBI_CFG:      rdata_d = sbi_cfg_q;
                `RSBS_OFF_STACK: begin
                    if (stk_cnt_q != '0) begin
                        rdata_d[`RSBS_STK_MORE] = 1'b1;
                        rdata_d[`RSBS_STK_WORD] = (word_q == rsbs_pkg::RSBS_WORD_ABCD);
                        rdata_d[4:0] = (word_q == rsbs_pkg::RSBS_WORD_ABCD) ?
                                       {1'b0, stk_q[stk_rptr_q].abcd} : stk_q[stk_rptr_q].chan;
                    end
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            proc_rdata_q <= 8'h00;
        end else if (proc_rd) begin
            proc_rdata_q <= rdata_d;
        end
    end

    // frame count within the multiframe, restarted by the multiframe sync
    always_ff @(posedge sys_clk) begin
        if (!rst_b || mf_edge) begin
            fcnt_q <= '0;
        end else if (frame_edge) begin
            fcnt_q <= (fcnt_q == `RSBS_FRAMES_PER_MF - 5'h01) ? '0 : fcnt_q + 5'h01;
        end
    end
    assign sig_idx = 2'(fcnt_q / `RSBS_FRAMES_PER_SIG);

    // pcm byte after robbed-bit insertion and embedded framing
    always_comb begin
        pcm_d = fifo_out.data;
        if (t1_mode && sig_cfg_q[`RSBS_CFG_ROBBED]
            && (fcnt_q % `RSBS_FRAMES_PER_SIG) == `RSBS_FRAMES_PER_SIG - 5'h01) begin
            pcm_d[0] = sigbuf_q[fifo_out.ts][7 - sig_idx];
        end
        if (t1_mode && sbi_cfg_q[`RSBS_SBI_EMBED]) begin
            if (fifo_out.ts == `RSBS_UNASSIGNED_TS_A || fifo_out.ts == `RSBS_UNASSIGNED_TS_B
                || fifo_out.ts > `RSBS_FBIT_TS) begin
                pcm_d = `RSBS_IDLE_BYTE;
            end else if (fifo_out.ts == `RSBS_FBIT_TS) begin
                pcm_d = `RSBS_IDLE_BYTE;
                pcm_d[`RSBS_FBIT_POS] = fifo_out.fbit;
            end
        end
    end

    // output stage registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pcm_out_valid_q       <= 1'b0;
            pcm_out_ts_q          <= '0;
            rx_pcm_output_q       <= `RSBS_IDLE_BYTE;
            rx_signaling_output_q <= '0;
        end else if (out_load) begin
            pcm_out_valid_q       <= 1'b1;
            pcm_out_ts_q          <= fifo_out.ts;
            rx_pcm_output_q       <= pcm_d;
            rx_signaling_output_q <= sigbuf_q[fifo_out.ts][7:4];
        end else if (pcm_out_ready) begin
            pcm_out_valid_q       <= 1'b0;
        end
    end

    // checks
    sequence s_mf_end_with_change;
        mf_edge && mf_changed_q;
    endsequence
    sequence s_second_read;
        stk_rd && word_q == rsbs_pkg::RSBS_WORD_ABCD && stk_cnt_q != '0 && !stk_push;
    endsequence

    property p_irq_on_change;
        @(posedge sys_clk) disable iff (!rst_b) s_mf_end_with_change |=> sig_irq;
    endproperty
    a_irq_on_change: assert property (p_irq_on_change) else $error("no interrupt after a changed multiframe");

    property p_every_mf;
        @(posedge sys_clk) disable iff (!rst_b)
            mf_edge && t1_mode && sig_cfg_q[`RSBS_CFG_EVERY_MF] |=> isr_q[`RSBS_ISR_SIG];
    endproperty
    a_every_mf: assert property (p_every_mf) else $error("every-multiframe interrupt missing");

    property p_irq_cause;
        @(posedge sys_clk) disable iff (!rst_b) $rose(sig_irq) |-> $past(mf_edge);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose away from a multiframe end");

    property p_stack_enable;
        @(posedge sys_clk) disable iff (!rst_b) stk_push |-> pcc_q[rx_sig_ts][`RSBS_PCC_STACK_EN];
    endproperty
    a_stack_enable: assert property (p_stack_enable) else $error("change stacked for a disabled channel");

    property p_more_bit;
        @(posedge sys_clk) disable iff (!rst_b)
            stk_rd |=> proc_rdata_q[`RSBS_STK_MORE] == ($past(stk_cnt_q) != '0);
    endproperty
    a_more_bit: assert property (p_more_bit) else $error("more bit disagrees with stack occupancy");

    property p_pop_after_second;
        @(posedge sys_clk) disable iff (!rst_b)
            s_second_read |=> stk_cnt_q == 6'($past(stk_cnt_q) - 6'h01);
    endproperty
    a_pop_after_second: assert property (p_pop_after_second) else $error("entry not removed on second read");

    property p_freeze;
        @(posedge sys_clk) disable iff (!rst_b)
            sig_cfg_q[`RSBS_CFG_FREEZE] && rx_sig_valid && !(proc_wr && sigbuf_hit)
            |=> sigbuf_q[$past(rx_sig_ts)][3:0] == $past(sigbuf_q[rx_sig_ts][3:0]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("buffer updated while frozen");

    property p_embed_fbit;
        @(posedge sys_clk) disable iff (!rst_b)
            out_load && t1_mode && sbi_cfg_q[`RSBS_SBI_EMBED] && fifo_out.ts == `RSBS_FBIT_TS
            |=> rx_pcm_output_q[`RSBS_FBIT_POS] == $past(fifo_out.fbit);
    endproperty
    a_embed_fbit: assert property (p_embed_fbit) else $error("framing bit not placed in ts26");

    property p_proc_write;
        @(posedge sys_clk) disable iff (!rst_b)
            proc_wr && sigbuf_hit |=> sigbuf_q[$past(proc_addr[4:0])] == $past(proc_wdata);
    endproperty
    a_proc_write: assert property (p_proc_write) else $error("processor overwrite lost");
endmodule : rsbs_top

// file: rsbs_highway_model.sv
// backplane highway sink that stalls every other cycle
`timescale 1ns/100ps
module rsbs_highway_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    input  wire logic [3:0] sig,
    output logic            ready_q,
    output logic      [7:0] data_q,
    output logic      [3:0] sig_q,
    output int              count_q
);
    // ready toggles so the output stage must hold its byte through stalls
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            count_q <= 0;
        end else begin
            ready_q <= ~ready_q;
            if (valid && ready_q) begin
                data_q  <= data;
                sig_q   <= sig;
                count_q <= count_q + 1;
            end
        end
    end
endmodule : rsbs_highway_model

// file: testbench.sv
// self-checking bench for the receive signaling buffer block
`timescale 1ns/100ps
module testbench;
    logic       sys_clk = 1'b0, rst_b = 1'b0, t1_mode = 1'b1;
    logic       sv = 1'b0, pv = 1'b0, pf = 1'b0, mfs = 1'b0, fs = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [4:0] sts = 5'h00, pts = 5'h00;
    logic [3:0] sab = 4'h0;
    logic [7:0] pb = 8'h00, wd = 8'h00;
    logic [8:0] addr = 9'h000;
    wire logic       pin_rdy, irq, ov, hw_rdy;
    wire logic [7:0] rdata, po, hw_d;
    wire logic [4:0] pots;
    wire logic [3:0] so, hw_s;
    int              hw_n;
    int              failures = 0;
    int              n_checks = 0;

    rsbs_top i_rsbs_top (.sys_clk(sys_clk), .rst_b(rst_b), .t1_mode(t1_mode), .rx_sig_valid(sv),
        .rx_sig_ts(sts), .rx_sig_abcd(sab), .pcm_in_valid(pv), .pcm_in_ts(pts), .pcm_in_byte(pb),
        .pcm_in_fbit(pf), .pcm_in_ready(pin_rdy), .rx_frame_sync(fs), .rx_multiframe_sync(mfs),
        .proc_addr(addr), .proc_rd(rd), .proc_wr(wr), .proc_wdata(wd), .proc_rdata_q(rdata),
        .pcm_out_ready(hw_rdy), .pcm_out_valid_q(ov), .pcm_out_ts_q(pots), .rx_pcm_output_q(po),
        .rx_signaling_output_q(so), .sig_irq(irq));
    rsbs_highway_model i_rsbs_highway_model (.sys_clk(sys_clk), .rst_b(rst_b), .valid(ov),
        .data(po), .sig(so), .ready_q(hw_rdy), .data_q(hw_d), .sig_q(hw_s), .count_q(hw_n));

    // 250 mhz clock
    always #2 sys_clk = ~sys_clk;

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // processor write, one cycle pulse
    task automatic wreg(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask : wreg

    // processor read, data is registered on the edge inside the pulse and checked as it ends
    task automatic rreg(input logic [8:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        chk(rdata, exp);
    endtask : rreg

    // one received abcd value for a slot
    task automatic sig(input logic [4:0] ts, input logic [3:0] ab);
        @(negedge sys_clk);
        sv = 1'b1;
        sts = ts;
        sab = ab;
        @(negedge sys_clk);
        sv = 1'b0;
    endtask : sig

    // multiframe sync pin pulse, then room for the sync chain
    task automatic mf();
        @(negedge sys_clk);
        mfs = 1'b1;
        repeat (4) @(negedge sys_clk);
        mfs = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask : mf

    // frame sync pin pulse, one detected rise per call
    task automatic fr();
        @(negedge sys_clk);
        fs = 1'b1;
        repeat (3) @(negedge sys_clk);
        fs = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : fr

    // one pcm byte through the fifo to the stalling highway
    task automatic pcm(input logic [4:0] ts, input logic [7:0] b, input logic f,
                       input logic [7:0] ed, input logic [3:0] es);
        int n;
        int k;
        n = hw_n;
        @(negedge sys_clk);
        pv = 1'b1;
        pts = ts;
        pb = b;
        pf = f;
        for (k = 0; k < 20 && pin_rdy !== 1'b1; k++) @(negedge sys_clk);
        @(negedge sys_clk);
        pv = 1'b0;
        for (k = 0; k < 20 && hw_n == n; k++) @(negedge sys_clk);
        chk(hw_d, ed);
        chk({4'h0, hw_s}, {4'h0, es});
    endtask : pcm

    // hang guard
    initial begin
        #40000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        rreg(9'h0d7, 8'h01);
        rreg(9'h183, 8'h00);
        rreg(9'h1bf, 8'h00);
        rreg(9'h0da, 8'h00);
        rreg(9'h0ff, 8'h00);
        wreg(9'h1bf, 8'ha5);
        rreg(9'h1bf, 8'ha5);
        $display("test reset and buffer done");
        // only slot 3 has stacking enabled
        wreg(9'h183, 8'h01);
        sig(5'h03, 4'h5);
        sig(5'h04, 4'h9);
        rreg(9'h1a3, 8'h05);
        rreg(9'h1a4, 8'h09);
        chk({7'h0, irq}, 8'h00);
        mf();
        chk({7'h0, irq}, 8'h01);
        rreg(9'h008, 8'h01);
        rreg(9'h0da, 8'h83);
        rreg(9'h0da, 8'hc5);
        rreg(9'h0da, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("test change stack done");
        // quiet multiframe, then the every-multiframe option
        mf();
        chk({7'h0, irq}, 8'h00);
        wreg(9'h0d7, 8'h10);
        mf();
        chk({7'h0, irq}, 8'h01);
        rreg(9'h008, 8'h01);
        $display("test multiframe interrupt done");
        // embedded framing with outgoing nibble on slot 5
        wreg(9'h1a5, 8'ha0);
        wreg(9'h0d0, 8'h01);
        pcm(5'h05, 8'h3c, 1'b0, 8'h3c, 4'ha);
        pcm(5'h00, 8'h12, 1'b1, 8'hff, 4'h0);
        pcm(5'h10, 8'h34, 1'b1, 8'hff, 4'h0);
        pcm(5'h1a, 8'h00, 1'b0, 8'h7f, 4'h0);
        pcm(5'h1b, 8'h56, 1'b1, 8'hff, 4'h0);
        $display("test embedded framing done");
        // robbed bit in the sixth frame carries the a bit of slot 5
        wreg(9'h0d7, 8'h01);
        repeat (5) fr();
        pcm(5'h05, 8'h3c, 1'b0, 8'h3d, 4'ha);
        $display("test robbed bit done");
        // freeze, then debounce needing two equal values
        wreg(9'h0d7, 8'h02);
        sig(5'h04, 4'h3);
        rreg(9'h1a4, 8'h09);
        wreg(9'h0d7, 8'h04);
        sig(5'h04, 4'h6);
        rreg(9'h1a4, 8'h09);
        sig(5'h04, 4'h6);
        rreg(9'h1a4, 8'h06);
        // unicode: slots 6 and 7, the only ones received in one multiframe, carry the same value
        wreg(9'h0d7, 8'h08);
        mf();
        sig(5'h06, 4'h6);
        sig(5'h07, 4'h6);
        mf();
        rreg(9'h008, 8'h02);
        $display("test freeze debounce unicode done");
        // e1: no every-multiframe interrupt and no embedding
        t1_mode = 1'b0;
        wreg(9'h0d7, 8'h10);
        mf();
        chk({7'h0, irq}, 8'h00);
        pcm(5'h00, 8'h12, 1'b1, 8'h12, 4'h0);
        $display("test e1 mode done");
        report_and_stop();
    end
endmodule : testbench
